// *** dsms_map.svh ***
// Purpose: Named constants for the dual supply mode sequencer.
// Assumes: 40 MHz clock, 25 ns period.
// Notes: Times are held in their own unit and turned into cycle counts here.
`ifndef DSMS_MAP_SVH
`define DSMS_MAP_SVH
`define DSMS_CLK_HZ 40000000
`define DSMS_UV_TIMEOUT_US 3000
`define DSMS_UV_TIMEOUT_CYC ((`DSMS_UV_TIMEOUT_US * (`DSMS_CLK_HZ / 1000000)))
`define DSMS_PAIR_WINDOW_US 60
`define DSMS_PAIR_WINDOW_CYC ((`DSMS_PAIR_WINDOW_US * (`DSMS_CLK_HZ / 1000000)))
`define DSMS_CNT_W 18
`endif

// *** dsms_pkg.sv ***
// Purpose: Types shared by the dual supply mode sequencer.
// Assumes: Nothing beyond the map header.
// Notes: Flag groups travel as packed structs.
package dsms_pkg;
  typedef enum logic [2:0] {
    DSMS_POWERUP = 3'h0,
    DSMS_STANDBY = 3'h1,
    DSMS_RUN = 3'h2,
    DSMS_OVP = 3'h3,
    DSMS_UVP = 3'h4,
    DSMS_SHUTDOWN = 3'h5,
    DSMS_THERMAL = 3'h6
  } dsms_mode_type;

  typedef struct packed {
    logic ov;
    logic uv;
    logic in_reg;
    logic out_high;
  } dsms_chan_flags_type;

  typedef struct packed {
    logic high_side;
    logic low_side;
    logic discharge;
  } dsms_gate_type;
endpackage

// *** dsms_sync.sv ***
// Purpose: Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes: Inputs come from analog comparators outside the clock domain.
// Notes: Only the second stage is visible.
`timescale 1ns/1ps
module dsms_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  initial begin
    if (W < 1) $error("dsms_sync: width must be positive.");
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule

// *** dsms_timer.sv ***
// Purpose: Saturating cycle counter that reports when a limit is reached.
// Assumes: Limit fits the counter width.
// Notes: Counting restarts whenever run drops.
`timescale 1ns/1ps
module dsms_timer #(
  parameter int W = 18
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [W-1:0] limit,
  output logic done
);
  logic [W-1:0] count_ff;

  initial begin
    if (W < 2) $error("dsms_timer: width too small.");
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= '0;
    end else if (!run) begin
      count_ff <= '0;
    end else if (count_ff != limit) begin
      count_ff <= count_ff + {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign done = run && (count_ff == limit);
endmodule

// *** dsms_top.sv ***
// Contract
// - Stay in power-up until input reset done and reference valid.
// - In power-up keep both linear regulators and reference enabled.
// - Run when master enable high and at least one channel enabled.
// - Output over 111 percent latches overvoltage; low gates high, regulators on.
// - Undervoltage forces all gates low, discharges, regulators stay on.
// - Fault latches cleared only by input reset or enable toggling.
// - Output still high in standby or shutdown is discharged.
// - Discharge closes the internal switch from output to ground.
// - Over 150 C turns all off until input reset or enable toggle; code only acts on it in standby, run and shutdown.
// - Enables within 60 us: later channel starts after earlier regulates.
// - Single channel starts when its enable comparator reports above 0.4 V.
//
// Purpose: Mode decision and power-up ordering for a dual step-down controller.
// Assumes: All comparator flags are asynchronous; input reset flag is high once done.
// Notes: No software registers; every control is a pin.
`timescale 1ns/1ps
`include "dsms_map.svh"
module dsms_top
  import dsms_pkg::*;
#(
  parameter int UV_TIMEOUT_CYC = `DSMS_UV_TIMEOUT_CYC,
  parameter int PAIR_WINDOW_CYC = `DSMS_PAIR_WINDOW_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic input_power_on_reset_done,
  input wire logic ref_valid,
  input wire logic master_enable,
  input wire logic channel_one_enable,
  input wire logic channel_two_enable,
  input wire logic over_temp,
  input wire dsms_chan_flags_type flags_one,
  input wire dsms_chan_flags_type flags_two,
  output logic ref_enable,
  output logic linear_reg_5v,
  output logic linear_reg_3v3,
  output logic switching_channel_one,
  output logic switching_channel_two,
  output dsms_gate_type gate_one,
  output dsms_gate_type gate_two,
  output dsms_mode_type mode
);
  localparam int CW = `DSMS_CNT_W;

  initial begin
    if (UV_TIMEOUT_CYC < 1 || UV_TIMEOUT_CYC >= (1 << CW))
      $error("dsms_top: undervoltage timeout out of range.");
    if (PAIR_WINDOW_CYC < 1 || PAIR_WINDOW_CYC >= (1 << CW))
      $error("dsms_top: pairing window out of range.");
  end

  logic [12:0] raw_in;
  logic [12:0] syn;
  assign raw_in = {input_power_on_reset_done, ref_valid, master_enable,
                   channel_one_enable, channel_two_enable, over_temp,
                   flags_one.ov, flags_one.uv, flags_one.in_reg, flags_one.out_high,
                   flags_two.ov, flags_two.uv, flags_two.in_reg};

  dsms_sync #(.W(13)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(raw_in),
    .sync_out(syn)
  );

  logic out_high_two;
  dsms_sync #(.W(1)) u_sync_oh2 (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(flags_two.out_high),
    .sync_out(out_high_two)
  );

  logic por_ok, refv, men, en1, en2, hot;
  logic ov1, uv1, reg1, oh1, ov2, uv2, reg2;
  assign {por_ok, refv, men, en1, en2, hot, ov1, uv1, reg1, oh1, ov2, uv2, reg2} = syn;

  dsms_mode_type mode_ff;
  dsms_mode_type nxt_mode;
  logic men_d_ff, en1_d_ff, en2_d_ff, por_d_ff;
  logic start1_ff, start2_ff;
  logic [CW-1:0] pair_cnt_ff;
  logic pair_open_ff;
  logic first_is_two_ff;

  // Any enable edge or a fresh input reset ends a latched fault state.
  logic toggle;
  assign toggle = (men != men_d_ff) || (en1 != en1_d_ff) || (en2 != en2_d_ff) ||
                  (por_ok && !por_d_ff);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      men_d_ff <= 1'b0;
      en1_d_ff <= 1'b0;
      en2_d_ff <= 1'b0;
      por_d_ff <= 1'b0;
    end else begin
      men_d_ff <= men;
      en1_d_ff <= en1;
      en2_d_ff <= en2;
      por_d_ff <= por_ok;
    end
  end

  // Pairing window: opened by the first enable rise, closed after 60 us.
  logic rise1, rise2;
  assign rise1 = en1 && !en1_d_ff;
  assign rise2 = en2 && !en2_d_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pair_cnt_ff <= '0;
      pair_open_ff <= 1'b0;
      first_is_two_ff <= 1'b0;
    end else if ((rise1 ^ rise2) && !pair_open_ff && !(en1 && en2)) begin
      pair_open_ff <= 1'b1;
      pair_cnt_ff <= '0;
      first_is_two_ff <= rise2;
    end else if (pair_open_ff) begin
      if (pair_cnt_ff == PAIR_WINDOW_CYC[CW-1:0] || !(en1 || en2)) begin
        pair_open_ff <= 1'b0;
      end else begin
        pair_cnt_ff <= pair_cnt_ff + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  // A channel rising inside the window waits for the other to regulate.
  // The wait is latched because the earlier channel may need longer than the
  // window to regulate; the window only bounds how close the two rises are.
  logic wait1_ff, wait2_ff;
  logic late1, late2;
  assign late1 = rise1 && pair_open_ff && first_is_two_ff;
  assign late2 = rise2 && pair_open_ff && !first_is_two_ff;

  // Dropping the earlier enable releases the wait, so the later one runs alone.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait1_ff <= 1'b0;
      wait2_ff <= 1'b0;
    end else begin
      wait1_ff <= en1 && en2 && !reg2 && (wait1_ff || late1);
      wait2_ff <= en2 && en1 && !reg1 && (wait2_ff || late2);
    end
  end

  logic hold1, hold2;
  assign hold1 = (wait1_ff || late1) && en2 && !reg2 && !start1_ff;
  assign hold2 = (wait2_ff || late2) && en1 && !reg1 && !start2_ff;

  logic running;
  assign running = (mode_ff == DSMS_RUN);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start1_ff <= 1'b0;
      start2_ff <= 1'b0;
    end else if (!running || !men) begin
      start1_ff <= 1'b0;
      start2_ff <= 1'b0;
    end else begin
      start1_ff <= en1 && (start1_ff || !hold1);
      start2_ff <= en2 && (start2_ff || !hold2);
    end
  end

  logic uv_done1, uv_done2;
  dsms_timer #(.W(CW)) u_uvt1 (
    .clk(clk),
    .rst_n(rst_n),
    .run(start1_ff),
    .limit(UV_TIMEOUT_CYC[CW-1:0]),
    .done(uv_done1)
  );
  dsms_timer #(.W(CW)) u_uvt2 (
    .clk(clk),
    .rst_n(rst_n),
    .run(start2_ff),
    .limit(UV_TIMEOUT_CYC[CW-1:0]),
    .done(uv_done2)
  );

  logic ov_any, uv_any;
  assign ov_any = (start1_ff && ov1) || (start2_ff && ov2);
  assign uv_any = (uv_done1 && uv1) || (uv_done2 && uv2);

  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      DSMS_POWERUP: begin
        if (por_ok && refv) nxt_mode = DSMS_SHUTDOWN;
      end
      DSMS_STANDBY, DSMS_RUN, DSMS_SHUTDOWN: begin
        if (hot) nxt_mode = DSMS_THERMAL;
        else if (running && ov_any) nxt_mode = DSMS_OVP;
        else if (running && uv_any) nxt_mode = DSMS_UVP;
        else if (!men) nxt_mode = DSMS_SHUTDOWN;
        else if (en1 || en2) nxt_mode = DSMS_RUN;
        else nxt_mode = DSMS_STANDBY;
      end
      DSMS_OVP, DSMS_UVP, DSMS_THERMAL: begin
        if (toggle) nxt_mode = DSMS_SHUTDOWN;
      end
      default: nxt_mode = DSMS_POWERUP;
    endcase
    if (!por_ok) nxt_mode = DSMS_POWERUP;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) mode_ff <= DSMS_POWERUP;
    else mode_ff <= nxt_mode;
  end

  // Outputs are registered so the gate drivers never see decode glitches.
  logic regs_on;
  assign regs_on = (mode_ff == DSMS_POWERUP) || (mode_ff == DSMS_OVP) ||
                   (mode_ff == DSMS_UVP) ||
                   ((mode_ff == DSMS_STANDBY || running) && refv);

  function automatic dsms_gate_type gate_of(input dsms_mode_type m, input logic started,
                                            input logic high);
    dsms_gate_type g;
    g = '{high_side: 1'b0, low_side: 1'b0, discharge: 1'b0};
    unique case (m)
      DSMS_RUN: g.high_side = started;
      DSMS_OVP: g.low_side = 1'b1;
      DSMS_UVP: g.discharge = 1'b1;
      DSMS_STANDBY, DSMS_SHUTDOWN: g.discharge = high;
      default: g = g;
    endcase
    if (m == DSMS_RUN && !started) g.discharge = high;
    return g;
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_enable <= 1'b0;
      linear_reg_5v <= 1'b0;
      linear_reg_3v3 <= 1'b0;
      switching_channel_one <= 1'b0;
      switching_channel_two <= 1'b0;
      gate_one <= '0;
      gate_two <= '0;
    end else begin
      ref_enable <= (mode_ff != DSMS_SHUTDOWN) && (mode_ff != DSMS_THERMAL);
      linear_reg_5v <= regs_on;
      linear_reg_3v3 <= regs_on;
      switching_channel_one <= running && start1_ff;
      switching_channel_two <= running && start2_ff;
      gate_one <= gate_of(mode_ff, running && start1_ff, oh1);
      gate_two <= gate_of(mode_ff, running && start2_ff, out_high_two);
    end
  end

  assign mode = mode_ff;
endmodule

// *** dsms_top_asserts.sv ***
// Purpose: Port assertions for the mode sequencer.
// Assumes: Outputs follow the mode one edge later.
// Notes: Mode checks need two cycles in a mode, so passing states are not judged.
`timescale 1ns/1ps
module dsms_top_asserts
  import dsms_pkg::*;
#(
  parameter int UV_TIMEOUT_CYC = 20,
  parameter int PAIR_WINDOW_CYC = 10
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic input_power_on_reset_done,
  input wire logic master_enable,
  input wire logic channel_one_enable,
  input wire logic channel_two_enable,
  input wire logic ref_enable,
  input wire logic linear_reg_5v,
  input wire logic linear_reg_3v3,
  input wire logic switching_channel_one,
  input wire logic switching_channel_two,
  input wire dsms_gate_type gate_one,
  input wire dsms_gate_type gate_two,
  input wire dsms_mode_type mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic regs;
  logic off;
  assign regs = linear_reg_5v && linear_reg_3v3;
  assign off = !(linear_reg_5v || linear_reg_3v3 ||
    switching_channel_one || switching_channel_two);
  sequence s_held(dsms_mode_type m);
    mode == m ##1 mode == m;
  endsequence
  a_powerup_keeps_on: assert property (s_held(DSMS_POWERUP) |-> ref_enable && regs)
    else $error("power-up output off");
  a_ovp_low_high: assert property (s_held(DSMS_OVP) |->
    gate_one.low_side && gate_two.low_side && regs) else $error("overvoltage outputs wrong");
  a_uvp_gates_low: assert property (s_held(DSMS_UVP) |->
    gate_one[2:1] == 2'h0 && gate_two[2:1] == 2'h0 && regs) else $error("undervoltage wrong");
  a_thermal_all_off: assert property (s_held(DSMS_THERMAL) |-> off && !ref_enable)
    else $error("thermal outputs on");
  a_shutdown_all_off: assert property (s_held(DSMS_SHUTDOWN) |-> off)
    else $error("shutdown outputs on");
  a_master_low_idle: assert property ((!master_enable)[*8] |->
    !(mode inside {DSMS_RUN, DSMS_STANDBY})) else $error("active with master low");
  a_fault_latch_holds: assert property ($stable({master_enable, channel_one_enable,
    channel_two_enable, input_power_on_reset_done})[*6] ##0
    mode inside {DSMS_OVP, DSMS_UVP, DSMS_THERMAL} |=> $stable(mode)) else $error("fault left");
  a_discharge_no_drive: assert property (!(gate_one[2] && gate_one[0]) &&
    !(gate_two[2] && gate_two[0])) else $error("discharge while driving");
endmodule
bind dsms_top dsms_top_asserts #(.UV_TIMEOUT_CYC(UV_TIMEOUT_CYC),
  .PAIR_WINDOW_CYC(PAIR_WINDOW_CYC)) u_asserts (.*);

// *** dsms_analog_model.sv ***
// Purpose: Comparator and output stand-in for one switching channel.
// Assumes: Regulation is reached a fixed time after the channel starts.
// Notes: Fault flags rise only on the bench's command.
`timescale 1ns/1ps
module dsms_analog_model
  import dsms_pkg::*;
#(
  parameter int SETTLE = 30
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic chan_on,
  input wire dsms_gate_type gate,
  input wire logic ov_cmd,
  input wire logic uv_cmd,
  output dsms_chan_flags_type flags
);
  int up_ff;
  logic high_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) up_ff <= 0;
    else up_ff <= chan_on ? ((up_ff < SETTLE) ? up_ff + 1 : up_ff) : 0;
  end
  // The output keeps its charge after the channel stops, until it is discharged.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) high_ff <= 1'h0;
    else if (gate.discharge) high_ff <= 1'h0;
    else if (chan_on && gate.high_side) high_ff <= 1'h1;
  end
  assign flags = '{ov: ov_cmd, uv: uv_cmd, in_reg: chan_on && up_ff >= SETTLE,
    out_high: high_ff};
endmodule

// *** dsms_top_bench.sv ***
// Purpose: Self-checking bench for the dual supply mode sequencer.
// Assumes: Timeout and pairing window cut to 20 and 10 cycles.
// Notes: Every wait is bounded and a hang ends in the verdict.
`timescale 1ns/1ps
module dsms_top_bench;
  import dsms_pkg::*;
  logic clk = 1'h0, rst_n = 1'h0, por = 1'h0, refv = 1'h0, men = 1'h0;
  logic en1 = 1'h0, en2 = 1'h0, ot = 1'h0, ov1 = 1'h0, uv2 = 1'h0;
  logic ref_en, reg5, reg3, sw1, sw2;
  dsms_chan_flags_type fl1, fl2;
  dsms_gate_type g1, g2;
  dsms_mode_type mode;
  logic [4:0][2:0] watch;
  int bad_count = 0;
  int checks_done = 0;
  assign watch = {2'h0, g2.discharge, 2'h0, g1.discharge, 2'h0, sw2, 2'h0, sw1, mode};
  dsms_top #(.UV_TIMEOUT_CYC(20), .PAIR_WINDOW_CYC(10)) DUT (
    .clk(clk), .rst_n(rst_n), .input_power_on_reset_done(por), .ref_valid(refv),
    .master_enable(men), .channel_one_enable(en1), .channel_two_enable(en2),
    .over_temp(ot), .flags_one(fl1), .flags_two(fl2), .ref_enable(ref_en),
    .linear_reg_5v(reg5), .linear_reg_3v3(reg3), .switching_channel_one(sw1),
    .switching_channel_two(sw2), .gate_one(g1), .gate_two(g2), .mode(mode));
  dsms_analog_model u_far1 (.clk(clk), .rst_n(rst_n), .chan_on(sw1), .gate(g1),
    .ov_cmd(ov1), .uv_cmd(1'h0), .flags(fl1));
  dsms_analog_model u_far2 (.clk(clk), .rst_n(rst_n), .chan_on(sw2), .gate(g2),
    .ov_cmd(1'h0), .uv_cmd(uv2), .flags(fl2));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic close_out;
    if (bad_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Index 0 is the mode, 1 and 2 the channels, 3 and 4 the discharge switches.
  task automatic wait_for(input int sel, input logic [2:0] val);
    int i;
    for (i = 0; i < 200 && watch[sel] !== val; i++) cyc(1);
    check(watch[sel], val);
    if (watch[sel] !== val) close_out;
    cyc(2);
  endtask
  task automatic t_powerup;
    cyc(8);
    check({mode, ref_en, reg5, reg3}, {DSMS_POWERUP, 3'h7});
    @(posedge clk) por <= 1'h1;
    cyc(8);
    check(mode, DSMS_POWERUP);
    @(posedge clk) refv <= 1'h1;
    wait_for(0, DSMS_SHUTDOWN);
    check({reg5, reg3, sw1, sw2}, 4'h0);
    @(posedge clk) men <= 1'h1;
    wait_for(0, DSMS_STANDBY);
    check({reg5, reg3, sw1, sw2}, 4'hC);
  endtask
  task automatic t_single;
    @(posedge clk) en1 <= 1'h1;
    wait_for(0, DSMS_RUN);
    wait_for(1, 3'h1);
    check({sw2, g1.high_side}, 2'h1);
    @(posedge clk) en1 <= 1'h0;
    wait_for(3, 3'h1);
    check({mode, g1.high_side}, {DSMS_STANDBY, 1'h0});
  endtask
  task automatic t_ovp;
    @(posedge clk) en1 <= 1'h1;
    wait_for(1, 3'h1);
    @(posedge clk) ov1 <= 1'h1;
    wait_for(0, DSMS_OVP);
    check({g1.low_side, g2.low_side, reg5, reg3}, 4'hF);
    @(posedge clk) ov1 <= 1'h0;
    cyc(10);
    check(mode, DSMS_OVP);
    @(posedge clk) men <= 1'h0;
    wait_for(0, DSMS_SHUTDOWN);
    @(posedge clk) men <= 1'h1;
    @(posedge clk) en1 <= 1'h0;
    wait_for(0, DSMS_STANDBY);
  endtask
  task automatic t_uvp;
    @(posedge clk) en2 <= 1'h1;
    wait_for(2, 3'h1);
    @(posedge clk) uv2 <= 1'h1;
    cyc(6);
    check(mode, DSMS_RUN);
    wait_for(0, DSMS_UVP);
    check({g1[2:1], g2[2:1], g2.discharge, reg5, reg3}, 7'h7);
    @(posedge clk) uv2 <= 1'h0;
    cyc(10);
    check(mode, DSMS_UVP);
    @(posedge clk) en2 <= 1'h0;
    wait_for(0, DSMS_STANDBY);
  endtask
  task automatic t_thermal;
    @(posedge clk) ot <= 1'h1;
    wait_for(0, DSMS_THERMAL);
    @(posedge clk) ot <= 1'h0;
    cyc(10);
    check({mode, ref_en, reg5, reg3, sw1, sw2}, {DSMS_THERMAL, 5'h0});
    @(posedge clk) men <= 1'h0;
    wait_for(0, DSMS_SHUTDOWN);
    @(posedge clk) men <= 1'h1;
    wait_for(0, DSMS_STANDBY);
  endtask
  task automatic t_pair;
    @(posedge clk) en2 <= 1'h1;
    @(posedge clk) en1 <= 1'h1;
    wait_for(2, 3'h1);
    repeat (20) begin
      cyc(1);
      check(sw1, 1'h0);
    end
    wait_for(1, 3'h1);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    t_powerup;
    t_single;
    t_ovp;
    t_uvp;
    t_thermal;
    t_pair;
    close_out;
  end
endmodule
